// file: design/tcs_timer_channel.sv
// Purpose : one timer channel's counter with source, edge and clear selection
// Assumes : compare, capture and phase pulses come from neighbouring logic
// Notes   : registers reached over AXI4-Lite, one word each
`timescale 1ns/10ps
module tcs_timer_channel
   import tcs_pkg::*;
#(
   parameter int CHANNEL = TCS_PHASE_CHAN
)(
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   input  wire logic        i_standby,
   input  wire logic [3:0]  i_ext_clk,
   input  wire logic        i_match_first,
   input  wire logic        i_capture_first,
   input  wire logic        i_match_second,
   input  wire logic        i_capture_second,
   input  wire logic        i_sync_clear,
   input  wire logic        i_phase_up,
   input  wire logic        i_phase_down,
   output logic [15:0]      o_count,
   output logic             o_sync_clear,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  control;
      logic [15:0] count;
      logic [3:0]  mode;
      logic        sync_out;
      logic        aw_got;
      logic [7:0]  awaddr;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } tcs_chan_state_t;

   tcs_chan_state_t s_reg, s_next;
   tcs_tick_if      tick_bus ();
   tcs_clear_t      clr_sel;
   logic            phase_on;
   logic            ev_first;
   logic            ev_second;
   logic            clear_hit;
   logic            sw_cnt_wr;

   // decodes an address to 0 control, 1 count, 2 mode, 3 unmapped
   function automatic logic [1:0] reg_sel(input logic [7:0] addr);
      logic [1:0] r;
      r = 2'h3;
      if (addr[7:2] == TCS_OFF_CONTROL[7:2]) r = 2'h0;
      if (addr[7:2] == TCS_OFF_COUNT[7:2])   r = 2'h1;
      if (addr[7:2] == TCS_OFF_MODE[7:2])    r = 2'h2;
      return r;
   endfunction

   // ****************************************************************
   // source selection and tick generation
   // ****************************************************************
   // phase mode only exists on the phase channel
   assign phase_on          = s_reg.mode[TCS_MODE_PHASE] && (CHANNEL == TCS_PHASE_CHAN);
   assign tick_bus.src_sel  = s_reg.control[TCS_CTL_SRC_LSB +: 3];
   assign tick_bus.edge_sel = s_reg.control[TCS_CTL_EDGE_LSB +: 2];
   assign tick_bus.phase_on = phase_on;

   tcs_clock_select u_clock_select (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_ext_clk(i_ext_clk),
      .bus      (tick_bus.gen)
   );

   // ****************************************************************
   // clear source
   // ****************************************************************
   // each general register feeds the clear from its active function
   always_comb begin
      clr_sel   = tcs_clear_t'(s_reg.control[TCS_CTL_CLR_LSB +: 2]);
      ev_first  = s_reg.mode[TCS_MODE_CAP_1ST] ? i_capture_first : i_match_first;
      ev_second = s_reg.mode[TCS_MODE_CAP_2ND] ? i_capture_second : i_match_second;
      unique case (clr_sel)
         TCS_CLR_NONE:   clear_hit = 1'b0;
         TCS_CLR_FIRST:  clear_hit = ev_first;
         TCS_CLR_SECOND: clear_hit = ev_second;
         TCS_CLR_SYNC:   clear_hit = i_sync_clear && s_reg.mode[TCS_MODE_SYNC];
      endcase
   end

   // ****************************************************************
   // next state: bus slave, registers and counter
   // ****************************************************************
   always_comb begin
      s_next    = s_reg;
      sw_cnt_wr = 1'b0;
      // address and data accepted in either order, one write at a time
      if (s_reg.awready && i_awvalid) begin
         s_next.aw_got  = 1'b1;
         s_next.awaddr  = i_awaddr;
         s_next.awready = 1'b0;
      end
      if (s_reg.wready && i_wvalid) begin
         s_next.w_got  = 1'b1;
         s_next.wdata  = i_wdata;
         s_next.wstrb  = i_wstrb;
         s_next.wready = 1'b0;
      end
      // counter: clear beats counting; phase pulses replace the tick
      if (clear_hit) begin
         s_next.count = TCS_COUNT_RESET;
      end else if (phase_on) begin
         if (i_phase_up && !i_phase_down) begin
            s_next.count = s_reg.count + 16'h0001;
         end else if (i_phase_down && !i_phase_up) begin
            s_next.count = s_reg.count - 16'h0001;
         end
      end else if (tick_bus.tick) begin
         s_next.count = s_reg.count + 16'h0001;
      end
      // partners see our own compare match or capture clears one cycle later
      s_next.sync_out = s_reg.mode[TCS_MODE_SYNC] && clear_hit && (clr_sel != TCS_CLR_SYNC);
      // register write once both halves are in
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = TCS_RESP_OKAY;
         unique case (reg_sel(s_reg.awaddr))
            2'h0: begin
               if (s_reg.wstrb[0]) begin
                  s_next.control = {1'b1, s_reg.wdata[6:0]};
               end
            end
            2'h1: begin
               // software load wins over a same-cycle tick or clear
               sw_cnt_wr = |s_reg.wstrb[1:0];
               if (s_reg.wstrb[0]) s_next.count[7:0]  = s_reg.wdata[7:0];
               if (s_reg.wstrb[1]) s_next.count[15:8] = s_reg.wdata[15:8];
            end
            2'h2: begin
               if (s_reg.wstrb[0]) s_next.mode = s_reg.wdata[3:0];
            end
            2'h3: s_next.bresp = TCS_RESP_SLV;
         endcase
      end
      if (s_reg.bvalid && i_bready) begin
         s_next.bvalid  = 1'b0;
         s_next.awready = 1'b1;
         s_next.wready  = 1'b1;
      end
      // read answer registered one cycle after the address
      if (s_reg.arready && i_arvalid) begin
         s_next.arready = 1'b0;
         s_next.rvalid  = 1'b1;
         s_next.rresp   = TCS_RESP_OKAY;
         unique case (reg_sel(i_araddr))
            2'h0: s_next.rdata = {24'h0, s_reg.control};
            2'h1: s_next.rdata = {16'h0, s_reg.count};
            2'h2: s_next.rdata = {28'h0, s_reg.mode};
            2'h3: begin
               s_next.rdata = 32'h0;
               s_next.rresp = TCS_RESP_SLV;
            end
         endcase
      end
      if (s_reg.rvalid && i_rready) begin
         s_next.rvalid  = 1'b0;
         s_next.arready = 1'b1;
      end
      // standby returns the timer registers to their reset values
      if (i_standby) begin
         s_next.control = TCS_CONTROL_RESET;
         s_next.count   = TCS_COUNT_RESET;
         s_next.mode    = TCS_MODE_RESET;
      end
   end

   // state register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_reg         <= '0;
         s_reg.control <= TCS_CONTROL_RESET;
         s_reg.awready <= 1'b1;
         s_reg.wready  <= 1'b1;
         s_reg.arready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_count      = s_reg.count;
   assign o_sync_clear = s_reg.sync_out;
   assign o_awready    = s_reg.awready;
   assign o_wready     = s_reg.wready;
   assign o_bvalid     = s_reg.bvalid;
   assign o_bresp      = s_reg.bresp;
   assign o_arready    = s_reg.arready;
   assign o_rvalid     = s_reg.rvalid;
   assign o_rresp      = s_reg.rresp;
   assign o_rdata      = s_reg.rdata;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_no_clear_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (s_reg.control[6:5] == 2'h0 && !i_standby && !sw_cnt_wr && !phase_on
       && s_reg.count != 16'h0 && s_reg.count != 16'hffff) |=> (o_count != 16'h0))
      else $error("counter cleared with clearing disabled");
   a_clear_first: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (s_reg.control[6:5] == 2'h1 && ev_first && !sw_cnt_wr) |=> (o_count == 16'h0))
      else $error("first register event did not clear");
   a_clear_second: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (s_reg.control[6:5] == 2'h2 && ev_second && !sw_cnt_wr) |=> (o_count == 16'h0))
      else $error("second register event did not clear");
   a_clear_sync: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (s_reg.control[6:5] == 2'h3 && s_reg.mode[TCS_MODE_SYNC] && i_sync_clear
       && !sw_cnt_wr) |=> (o_count == 16'h0))
      else $error("synchronous clear missed");
   a_capture_trigger: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (s_reg.control[6:5] == 2'h1 && s_reg.mode[TCS_MODE_CAP_1ST]
       && i_match_first && !i_capture_first) |-> !clear_hit)
      else $error("compare match cleared a capture-mode counter");
   a_phase_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (phase_on && !i_phase_up && !i_phase_down && !clear_hit && !sw_cnt_wr
       && !i_standby) |=> $stable(o_count))
      else $error("counter moved in phase mode without a phase pulse");
   a_reserved_one: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (i_arvalid && o_arready && reg_sel(i_araddr) == 2'h0) |=> o_rdata[7])
      else $error("control bit 7 read as zero");
   a_count_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (tick_bus.tick && !phase_on && !clear_hit && !sw_cnt_wr && !i_standby)
      |=> (o_count == $past(o_count) + 16'h0001))
      else $error("counter did not step by one");
   // partners only learn of clears this channel made itself, never echoes
   a_sync_out: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (s_reg.mode[TCS_MODE_SYNC] && clear_hit && clr_sel != TCS_CLR_SYNC)
      |=> o_sync_clear)
      else $error("own clear not passed to synchronized partners");
   a_sync_quiet: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (!clear_hit) |=> !o_sync_clear)
      else $error("partner clear raised without a clear");
   // standby wins over every other counter source
   a_standby_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_standby |=> (o_count == TCS_COUNT_RESET))
      else $error("standby left the counter running");
endmodule

// file: pkg/tcs_pkg.sv
// Purpose : shared constants and types of the timer count source and clear select block
// Assumes : one system clock, AXI4-Lite register access
// Notes   : offsets are byte addresses of aligned 32-bit words
package tcs_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0]  TCS_OFF_CONTROL   = 8'h00;
   localparam logic [7:0]  TCS_OFF_COUNT     = 8'h04;
   localparam logic [7:0]  TCS_OFF_MODE      = 8'h08;
   localparam logic [7:0]  TCS_CONTROL_RESET = 8'h80;
   localparam logic [15:0] TCS_COUNT_RESET   = 16'h0000;
   localparam logic [3:0]  TCS_MODE_RESET    = 4'h0;
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int TCS_CTL_RSV_BIT  = 7;
   localparam int TCS_CTL_CLR_LSB  = 5;
   localparam int TCS_CTL_EDGE_LSB = 3;
   localparam int TCS_CTL_SRC_LSB  = 0;
   localparam int TCS_MODE_PHASE   = 0;
   localparam int TCS_MODE_SYNC    = 1;
   localparam int TCS_MODE_CAP_1ST = 2;
   localparam int TCS_MODE_CAP_2ND = 3;
   localparam int TCS_PHASE_CHAN   = 2;
   localparam int TCS_PRESC_W      = 3;
   // ****************************************************************
   // encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      TCS_CLR_NONE   = 2'h0,
      TCS_CLR_FIRST  = 2'h1,
      TCS_CLR_SECOND = 2'h2,
      TCS_CLR_SYNC   = 2'h3
   } tcs_clear_t;
   localparam logic [1:0] TCS_EDGE_RISE = 2'h0;
   localparam logic [1:0] TCS_EDGE_FALL = 2'h1;
   localparam logic [1:0] TCS_RESP_OKAY = 2'h0;
   localparam logic [1:0] TCS_RESP_SLV  = 2'h2;
endpackage

// file: pkg/tcs_tick_if.sv
// Purpose : carries source selection down and the count tick back up
// Assumes : both ends on i_mclk
// Notes   : tick is high for one cycle per count, so it stays high on the every-cycle source
`timescale 1ns/10ps
interface tcs_tick_if;
   logic [2:0] src_sel;
   logic [1:0] edge_sel;
   logic       phase_on;
   logic       tick;
   modport ctrl (output src_sel, output edge_sel, output phase_on, input tick);
   modport gen  (input src_sel, input edge_sel, input phase_on, output tick);
endinterface

// file: design/tcs_clock_select.sv
// Purpose : prescaler taps, external pin sampling and count tick generation
// Assumes : external clock pins are far slower than i_mclk
// Notes   : tick lags the qualifying edge by one cycle
`timescale 1ns/10ps
module tcs_clock_select
   import tcs_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   input  wire logic [3:0] i_ext_clk,
   tcs_tick_if.gen         bus
);
   typedef struct packed {
      logic [TCS_PRESC_W-1:0] presc;
      logic [3:0]             ext_s1;
      logic [3:0]             ext_s2;
      logic [3:0]             ext_prev;
      logic                   tick;
   } tcs_gen_state_t;

   tcs_gen_state_t s_reg, s_next;
   logic           pin_cur;
   logic           pin_old;

   // ****************************************************************
   // next state
   // ****************************************************************
   // falling edge of a divided tap is the cycle its low bits are all ones
   always_comb begin
      s_next        = s_reg;
      s_next.presc  = s_reg.presc + 3'h1;
      s_next.ext_s1 = i_ext_clk;
      s_next.ext_s2 = s_reg.ext_s1;
      s_next.ext_prev = s_reg.ext_s2;
      pin_cur       = s_reg.ext_s2[bus.src_sel[1:0]];
      pin_old       = s_reg.ext_prev[bus.src_sel[1:0]];
      s_next.tick   = 1'b0;
      if (bus.phase_on) begin
         s_next.tick = 1'b0;
      end else if (!bus.src_sel[2]) begin
         unique case (bus.src_sel[1:0])
            2'h0: s_next.tick = 1'b1;
            2'h1: s_next.tick = s_reg.presc[0];
            2'h2: s_next.tick = &s_reg.presc[1:0];
            2'h3: s_next.tick = &s_reg.presc[2:0];
         endcase
      end else begin
         // pin index picked by the low source bits
         if (bus.edge_sel[1]) begin
            s_next.tick = pin_cur ^ pin_old;
         end else if (bus.edge_sel == TCS_EDGE_FALL) begin
            s_next.tick = pin_old & ~pin_cur;
         end else begin
            s_next.tick = pin_cur & ~pin_old;
         end
      end
   end

   // state register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus.tick = s_reg.tick;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_both_edges: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (bus.src_sel[2] && bus.edge_sel[1] && !bus.phase_on && pin_cur != pin_old)
      |=> bus.tick)
      else $error("both-edge mode missed an edge");
   a_rise_only: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (bus.src_sel[2] && bus.edge_sel == TCS_EDGE_RISE && !bus.phase_on
       && pin_old && !pin_cur) |=> !bus.tick)
      else $error("rising mode counted a falling edge");
   a_div_two: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (bus.src_sel == 3'h1 && !bus.phase_on)[*3] |-> (bus.tick != $past(bus.tick)))
      else $error("divide by two tap not alternating");
   a_div_eight: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (bus.src_sel == 3'h3 && $past(bus.src_sel) == 3'h3 && !bus.phase_on && bus.tick)
      |=> !bus.tick[*7])
      else $error("divide by eight tap ticked early");
endmodule

// file: tb/tcs_ext_pins.sv
// Purpose : far side model driving the four external clock pins
// Assumes : one pin pulses at a time, 8 system cycles per pulse
// Notes   : pins stay low outside a requested pulse train
`timescale 1ns/10ps
module tcs_ext_pins (
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   input  wire logic [1:0] i_pin,
   input  wire logic [7:0] i_pulses,
   input  wire logic       i_start,
   output logic [3:0]      o_ext_clk,
   output logic            o_busy
);
   logic [10:0] left_reg;
   // ****************************************************************
   // pulse train
   // ****************************************************************
   // slow pulses so every level lasts well past the pin synchronizer
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) left_reg <= 11'h0;
      else if (i_start) left_reg <= {i_pulses, 3'h0};
      else if (left_reg != 11'h0) left_reg <= left_reg - 11'h1;
   end
   // selected pin high in the upper half of each 8-cycle slot, ends low
   always_comb begin
      o_ext_clk = 4'h0;
      o_ext_clk[i_pin] = left_reg[2];
      o_busy = (left_reg != 11'h0);
   end
endmodule

// file: tb/testbench.sv
// Purpose : self-checking bench for one timer channel
// Assumes : channel 2 build, registers over AXI4-Lite
// Notes   : read answers are checked against a queue of notes
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module testbench;
   import tcs_pkg::*;
   logic clk, rstn, stby, m1, c1, m2, c2, sy, pu, pd, start, busy, sync_out;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr, pulses;
   logic [31:0] wdata, rdata, lfsr_state;
   logic [3:0]  wstrb, ext;
   logic [1:0]  bresp, rresp, pin;
   logic [15:0] cnt, c0, v;
   logic [33:0] mon_exp;
   logic [9:0]  cases [12];
   logic [33:0] exp_q [$];
   int          bad_count, samples_checked;

   tcs_timer_channel u_dut (.i_mclk(clk), .i_resetn(rstn), .i_standby(stby), .i_ext_clk(ext),
      .i_match_first(m1), .i_capture_first(c1), .i_match_second(m2), .i_capture_second(c2),
      .i_sync_clear(sy), .i_phase_up(pu), .i_phase_down(pd), .o_count(cnt),
      .o_sync_clear(sync_out), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));
   tcs_ext_pins u_pins (.i_mclk(clk), .i_resetn(rstn), .i_pin(pin), .i_pulses(pulses),
      .i_start(start), .o_ext_clk(ext), .o_busy(busy));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic ran_out();
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      stop_test();
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
         if (ad && wd && bvalid) break;
      end
      // bready stays up so a following write never drives it twice in a step
      if (n == 50) ran_out();
   endtask
   // read: the expected answer is noted before the request goes out
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      logic ad;
      ad = 1'b0;
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) begin
            ad = 1'b1;
            arvalid <= 1'b0;
         end
         if (ad && rvalid) break;
      end
      if (n == 50) ran_out();
   endtask
   // train of slow pulses on one pin, then let the synchronizer drain
   task automatic pins_run(input logic [1:0] p, input logic [7:0] k);
      int n;
      pin <= p;
      pulses <= k;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (n = 0; n < 400; n++) begin
         @(posedge clk);
         if (!busy) break;
      end
      if (n == 400) ran_out();
      repeat (6) @(posedge clk);
   endtask

   // ****************************************************************
   // clock, answer monitor
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // oldest note against each read answer
   always @(posedge clk) begin
      if (rvalid && rready) begin
         mon_exp = exp_q.pop_front();
         `CHK({rresp, rdata}, mon_exp)
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rstn, stby, m1, c1, m2, c2, sy, pu, pd, start} = 10'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, pulses, pin, wdata} = 58'h0;
      wstrb = 4'hf;
      lfsr_state = 32'hb45e;
      bad_count = 0;
      samples_checked = 0;
      cases = '{10'h000, 10'h101, 10'h102, 10'h143, 10'h140, 10'h205, 10'h200, 10'h287,
                10'h329, 10'h308, 10'h028, 10'h121};
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // reset value, fixed bit 7, unmapped place
      rd(TCS_OFF_CONTROL, {TCS_RESP_OKAY, 24'h0, TCS_CONTROL_RESET});
      wr(TCS_OFF_CONTROL, 32'h0);
      rd(TCS_OFF_CONTROL, {TCS_RESP_OKAY, 32'h80});
      rd(8'h0c, {TCS_RESP_SLV, 32'h0});
      $display("test registers done");
      // internal taps: ticks over a fixed window of 16 cycles
      for (int d = 0; d < 4; d++) begin
         wr(TCS_OFF_CONTROL, 32'h80 | d);
         @(posedge clk);
         c0 = cnt;
         repeat (16) @(posedge clk);
         `CHK(16'(cnt - c0), 16'd16 >> d)
      end
      $display("test internal taps done");
      // every pin with every edge code, three pulses each
      for (int p = 0; p < 4; p++) begin
         for (int e = 0; e < 4; e++) begin
            wr(TCS_OFF_CONTROL, 32'h84 | (e << 3) | p);
            wr(TCS_OFF_COUNT, 32'h0);
            pins_run(2'(p), 8'd3);
            rd(TCS_OFF_COUNT, {18'h0, (e >= 2) ? 16'd6 : 16'd3});
         end
      end
      $display("test external pins done");
      // clear sources against the clear code and register modes
      foreach (cases[i]) begin
         wr(TCS_OFF_MODE, {28'h0, cases[i][7:4]});
         wr(TCS_OFF_CONTROL, 32'h84 | (cases[i][9:8] << 5));
         lfsr_state = lfsr_next(lfsr_state);
         v = lfsr_state[15:0] | 16'h1;
         wr(TCS_OFF_COUNT, {16'h0, v});
         {sy, c2, m2, c1, m1} <= 5'h1 << cases[i][3:1];
         @(posedge clk);
         {sy, c2, m2, c1, m1} <= 5'h0;
         @(posedge clk);
         `CHK(cnt, cases[i][0] ? 16'h0 : v)
         `CHK(sync_out, cases[i][5] && cases[i][0] && cases[i][9:8] != 2'h3)
      end
      $display("test clear select done");
      // phase counting overrides an every-cycle source
      wr(TCS_OFF_MODE, 32'h1);
      wr(TCS_OFF_CONTROL, 32'h90);
      wr(TCS_OFF_COUNT, 32'h0);
      pu <= 1'b1;
      repeat (3) @(posedge clk);
      pu <= 1'b0;
      pd <= 1'b1;
      @(posedge clk);
      pd <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(cnt, 16'd2)
      $display("test phase mode done");
      // standby restores the control reset value
      wr(TCS_OFF_CONTROL, 32'h1f);
      stby <= 1'b1;
      repeat (2) @(posedge clk);
      stby <= 1'b0;
      @(posedge clk);
      rd(TCS_OFF_CONTROL, {TCS_RESP_OKAY, 32'h80});
      @(posedge clk);
      $display("test standby done");
      stop_test();
   end
endmodule
